// file: ebaju_pkg.sv
// constants, operation codes and carriers for the byte alu and jump unit
// assumes a single pclk domain and an apb master on the register side
package ebaju_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OPA = 8'h04;
    localparam logic [7:0] ADDR_OPB = 8'h08;
    localparam logic [7:0] ADDR_SREG = 8'h0c;
    localparam logic [7:0] ADDR_PC = 8'h10;
    localparam logic [7:0] ADDR_RES = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_START_BIT = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;

    // ------------------------------------------------------------
    // reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [7:0] RST_SREG = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // ------------------------------------------------------------
    // operations
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        op_add,
        op_add_carry,
        op_pair_plus_immediate,
        op_sub,
        op_difference_immediate,
        op_difference_with_borrow,
        op_difference_borrow_immediate,
        op_pair_minus_immediate,
        op_and,
        op_bitwise_conjunction_immediate,
        op_or,
        op_bitwise_union_immediate,
        op_bitwise_exclusive_union,
        op_mask_bits_high,
        op_mask_bits_low,
        op_zero_minus_check,
        op_zero_the_reg,
        op_all_ones_load,
        op_inc,
        op_minus_one,
        op_unsigned_product,
        op_signed_product,
        op_mixed_sign_product,
        op_fraction_product_unsigned,
        op_fraction_product_signed,
        op_fraction_product_mixed,
        op_pointer_branch,
        op_pointer_subroutine_entry,
        op_offset_branch,
        op_offset_subroutine_entry,
        op_absolute_branch
    } ebaju_op_e;

    typedef enum {
        st_idle,
        st_exec
    } ebaju_state_e;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic h;
        logic v;
    } ebaju_arith_s;

    typedef struct packed {
        logic [15:0] prod;
        logic c;
    } ebaju_mul_s;

endpackage

// file: ebaju_addsub8.sv
// byte adder and subtractor with carry, half-carry and overflow
// assumes purely combinational use inside the execution unit
`timescale 1ns/1ps
module ebaju_addsub8 (
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic sub,
    // result
    output ebaju_pkg::ebaju_arith_s out
);
    wire [8:0] full = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
                          : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
    wire [4:0] nib = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
                         : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
    // overflow: sign of result disagrees with what the operand signs allow
    wire same_sign = sub ? (a[7] != b[7]) : (a[7] == b[7]);

    assign out.res = full[7:0];
    assign out.c = full[8];
    assign out.h = nib[4];
    assign out.v = same_sign && (full[7] != a[7]);
endmodule // ebaju_addsub8

// file: ebaju_mul8.sv
// byte multiplier, each operand signed or unsigned, optional fraction shift
// assumes purely combinational use inside the execution unit
`timescale 1ns/1ps
module ebaju_mul8 (
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    // result
    output ebaju_pkg::ebaju_mul_s out
);
    wire signed [8:0] sa = {a_signed & a[7], a};
    wire signed [8:0] sb = {b_signed & b[7], b};
    wire signed [17:0] p = sa * sb;
    // carry is bit 15 of the product before the fraction shift drops it
    assign out.c = p[15];
    assign out.prod = frac ? {p[14:0], 1'b0} : p[15:0];
endmodule // ebaju_mul8

// file: ebaju_core.sv
// byte alu and jump unit with an apb register front end
// assumes the apb master keeps the request stable until pready
//
// Overview of operation
// RQ1: add and add-with-carry write sum, update Z C N V H, one clock.
// RQ2: pair plus immediate writes 16-bit sum, updates Z C N V S, two clocks.
// RQ3: subtract register or constant, updates Z C N V H, one clock.
// RQ4: subtract register with borrow, updates Z C N V H, one clock.
// RQ5: subtract constant with borrow, updates Z C N V H, one clock.
// RQ6: pair minus immediate writes 16-bit difference, updates Z C N V S, two clocks.
// RQ7: and with register or constant updates only Z N V, one clock.
// RQ8: or and exclusive or update only Z N V, one clock.
// RQ9: mask high ors constant, mask low ands inverted constant, Z N V, one clock.
// RQ10: zero-minus check keeps value, sets Z N V, one clock.
// RQ11: integer products write 16-bit result pair, update Z C, two clocks.
// RQ12: fraction products shift product left once, update Z C, two clocks.
// RQ13: pointer branch loads pc from pointer pair, no flags, two clocks.
// RQ14: pointer subroutine entry loads pc from pointer, no flags, three clocks.
// RQ15: offset branch and entry add offset plus one; absolute loads it.
// RQ16: inc and dec update Z N V; all ones load touches no flag.
`timescale 1ns/1ps
module ebaju_core #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // architectural state seen by the core
    output logic [15:0] pc_o,
    output logic [7:0] sreg_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ebaju_pkg::ebaju_state_e state_q;
    ebaju_pkg::ebaju_op_e op_q;
    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic [7:0] sreg_q;
    logic [15:0] pc_q;
    logic [15:0] res_q;
    logic [1:0] cnt_q;
    logic done_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [15:0] res_d;
    logic [7:0] sreg_d;
    logic [15:0] pc_d;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [7:0] addr = paddr[7:0];
    wire busy = (state_q == ebaju_pkg::st_exec);
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite && pready_q;
    // operand and state writes are dropped while busy so a run stays coherent
    wire wr_idle = apb_wr && !busy;
    wire sel_ctrl = (addr == ebaju_pkg::ADDR_CTRL);
    wire sel_opa = (addr == ebaju_pkg::ADDR_OPA);
    wire sel_opb = (addr == ebaju_pkg::ADDR_OPB);
    wire sel_sreg = (addr == ebaju_pkg::ADDR_SREG);
    wire sel_pc = (addr == ebaju_pkg::ADDR_PC);
    wire sel_res = (addr == ebaju_pkg::ADDR_RES);
    wire sel_stat = (addr == ebaju_pkg::ADDR_STAT);
    wire hit = sel_ctrl || sel_opa || sel_opb || sel_sreg || sel_pc || sel_res || sel_stat;
    wire start = wr_idle && sel_ctrl && pwdata[ebaju_pkg::CTRL_START_BIT];
    wire [4:0] wop = pwdata[4:0];
    wire fin = busy && (cnt_q == ebaju_pkg::CYC_ONE);

    wire [31:0] rd_mux =
        sel_ctrl ? {27'h0000000, op_q} :
        sel_opa ? {16'h0000, opa_q} :
        sel_opb ? {16'h0000, opb_q} :
        sel_sreg ? {24'h000000, sreg_q} :
        sel_pc ? {16'h0000, pc_q} :
        sel_res ? {16'h0000, res_q} :
        sel_stat ? {30'h00000000, done_q, busy} : 32'h00000000;

    // ------------------------------------------------------------
    // cycle counts per operation
    // ------------------------------------------------------------
    function automatic logic [1:0] cycles_of(input logic [4:0] op);
        case (ebaju_pkg::ebaju_op_e'(op))
            ebaju_pkg::op_pair_plus_immediate, ebaju_pkg::op_pair_minus_immediate,
            ebaju_pkg::op_unsigned_product, ebaju_pkg::op_signed_product,
            ebaju_pkg::op_mixed_sign_product, ebaju_pkg::op_fraction_product_unsigned,
            ebaju_pkg::op_fraction_product_signed, ebaju_pkg::op_fraction_product_mixed,
            ebaju_pkg::op_pointer_branch, ebaju_pkg::op_offset_branch:
                cycles_of = ebaju_pkg::CYC_TWO; // RQ2 RQ6 RQ11 RQ12 RQ13 RQ15
            ebaju_pkg::op_pointer_subroutine_entry, ebaju_pkg::op_offset_subroutine_entry,
            ebaju_pkg::op_absolute_branch:
                cycles_of = ebaju_pkg::CYC_THREE; // RQ14 RQ15
            default:
                cycles_of = ebaju_pkg::CYC_ONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // operand selection
    // ------------------------------------------------------------
    wire is_sub = (op_q == ebaju_pkg::op_sub) || (op_q == ebaju_pkg::op_difference_immediate)
        || (op_q == ebaju_pkg::op_difference_with_borrow)
        || (op_q == ebaju_pkg::op_difference_borrow_immediate);
    wire use_c = (op_q == ebaju_pkg::op_add_carry)
        || (op_q == ebaju_pkg::op_difference_with_borrow)
        || (op_q == ebaju_pkg::op_difference_borrow_immediate);
    wire [7:0] a8 = opa_q[7:0];
    wire [7:0] b8 = opb_q[7:0];
    ebaju_pkg::ebaju_arith_s ar;
    ebaju_pkg::ebaju_mul_s mu;

    ebaju_addsub8 u_addsub (
        .a(a8),
        .b(b8),
        .cin(use_c && sreg_q[ebaju_pkg::FLG_C]), // RQ1 RQ4 RQ5
        .sub(is_sub), // RQ3
        .out(ar)
    );

    wire mul_as = (op_q == ebaju_pkg::op_signed_product)
        || (op_q == ebaju_pkg::op_mixed_sign_product)
        || (op_q == ebaju_pkg::op_fraction_product_signed)
        || (op_q == ebaju_pkg::op_fraction_product_mixed);
    wire mul_bs = (op_q == ebaju_pkg::op_signed_product)
        || (op_q == ebaju_pkg::op_fraction_product_signed);
    wire mul_fr = (op_q == ebaju_pkg::op_fraction_product_unsigned)
        || (op_q == ebaju_pkg::op_fraction_product_signed)
        || (op_q == ebaju_pkg::op_fraction_product_mixed);

    ebaju_mul8 u_mul (
        .a(a8),
        .b(b8),
        .a_signed(mul_as),
        .b_signed(mul_bs),
        .frac(mul_fr), // RQ12
        .out(mu)
    );

    // pair arithmetic on the high:low register pair held in opa
    wire pair_sub = (op_q == ebaju_pkg::op_pair_minus_immediate);
    wire [16:0] pair_full = pair_sub ? ({1'b0, opa_q} - {9'h000, b8})
                                     : ({1'b0, opa_q} + {9'h000, b8});
    wire [15:0] pair_r = pair_full[15:0];
    wire pair_v = pair_sub ? (opa_q[15] && !pair_r[15]) : (!opa_q[15] && pair_r[15]);

    // logic group result and its overflow flag
    wire [7:0] lg =
        (op_q == ebaju_pkg::op_and) ? (a8 & b8) :
        (op_q == ebaju_pkg::op_bitwise_conjunction_immediate) ? (a8 & b8) :
        (op_q == ebaju_pkg::op_or) ? (a8 | b8) :
        (op_q == ebaju_pkg::op_bitwise_union_immediate) ? (a8 | b8) :
        (op_q == ebaju_pkg::op_bitwise_exclusive_union) ? (a8 ^ b8) :
        (op_q == ebaju_pkg::op_mask_bits_high) ? (a8 | b8) :
        (op_q == ebaju_pkg::op_mask_bits_low) ? (a8 & ~b8) :
        (op_q == ebaju_pkg::op_zero_minus_check) ? (a8 & a8) :
        (op_q == ebaju_pkg::op_inc) ? (a8 + 8'h01) :
        (op_q == ebaju_pkg::op_minus_one) ? (a8 - 8'h01) : 8'h00;
    wire lg_v = ((op_q == ebaju_pkg::op_inc) && (lg == 8'h80))
        || ((op_q == ebaju_pkg::op_minus_one) && (lg == 8'h7f));

    // ------------------------------------------------------------
    // result, flag and pc update at the last execution cycle
    // ------------------------------------------------------------
    always_comb
    begin
        res_d = res_q;
        sreg_d = sreg_q;
        pc_d = pc_q;
        case (op_q)
            ebaju_pkg::op_add, ebaju_pkg::op_add_carry, ebaju_pkg::op_sub,
            ebaju_pkg::op_difference_immediate, ebaju_pkg::op_difference_with_borrow,
            ebaju_pkg::op_difference_borrow_immediate:
            begin
                res_d = {8'h00, ar.res}; // RQ1 RQ3 RQ4 RQ5
                sreg_d[ebaju_pkg::FLG_Z] = (ar.res == 8'h00);
                sreg_d[ebaju_pkg::FLG_C] = ar.c;
                sreg_d[ebaju_pkg::FLG_N] = ar.res[7];
                sreg_d[ebaju_pkg::FLG_V] = ar.v;
                sreg_d[ebaju_pkg::FLG_H] = ar.h;
            end
            ebaju_pkg::op_pair_plus_immediate, ebaju_pkg::op_pair_minus_immediate:
            begin
                res_d = pair_r; // RQ2 RQ6
                sreg_d[ebaju_pkg::FLG_Z] = (pair_r == 16'h0000);
                sreg_d[ebaju_pkg::FLG_C] = pair_full[16];
                sreg_d[ebaju_pkg::FLG_N] = pair_r[15];
                sreg_d[ebaju_pkg::FLG_V] = pair_v;
                sreg_d[ebaju_pkg::FLG_S] = pair_r[15] ^ pair_v;
            end
            ebaju_pkg::op_and, ebaju_pkg::op_bitwise_conjunction_immediate, ebaju_pkg::op_or,
            ebaju_pkg::op_bitwise_union_immediate, ebaju_pkg::op_bitwise_exclusive_union,
            ebaju_pkg::op_mask_bits_high, ebaju_pkg::op_mask_bits_low,
            ebaju_pkg::op_zero_minus_check, ebaju_pkg::op_inc, ebaju_pkg::op_minus_one:
            begin
                res_d = {8'h00, lg}; // RQ7 RQ8 RQ9 RQ10 RQ16
                sreg_d[ebaju_pkg::FLG_Z] = (lg == 8'h00);
                sreg_d[ebaju_pkg::FLG_N] = lg[7];
                sreg_d[ebaju_pkg::FLG_V] = lg_v;
            end
            ebaju_pkg::op_zero_the_reg:
            begin
                res_d = ebaju_pkg::RST_WORD;
                sreg_d[ebaju_pkg::FLG_Z] = 1'b1;
                sreg_d[ebaju_pkg::FLG_N] = 1'b0;
                sreg_d[ebaju_pkg::FLG_V] = 1'b0;
            end
            ebaju_pkg::op_all_ones_load:
                res_d = {8'h00, 8'hff}; // RQ16
            ebaju_pkg::op_unsigned_product, ebaju_pkg::op_signed_product,
            ebaju_pkg::op_mixed_sign_product, ebaju_pkg::op_fraction_product_unsigned,
            ebaju_pkg::op_fraction_product_signed, ebaju_pkg::op_fraction_product_mixed:
            begin
                res_d = mu.prod; // RQ11 RQ12
                sreg_d[ebaju_pkg::FLG_Z] = (mu.prod == 16'h0000);
                sreg_d[ebaju_pkg::FLG_C] = mu.c;
            end
            ebaju_pkg::op_pointer_branch, ebaju_pkg::op_pointer_subroutine_entry:
                pc_d = opa_q; // RQ13 RQ14
            ebaju_pkg::op_offset_branch, ebaju_pkg::op_offset_subroutine_entry:
                pc_d = pc_q + opb_q + 16'h0001; // RQ15
            ebaju_pkg::op_absolute_branch:
                pc_d = opb_q; // RQ15
            default:
                res_d = res_q;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ebaju_pkg::st_idle;
            op_q <= ebaju_pkg::op_add;
            cnt_q <= ebaju_pkg::CYC_ONE;
            done_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ebaju_pkg::st_idle:
                    if (start)
                    begin
                        state_q <= ebaju_pkg::st_exec;
                        op_q <= ebaju_pkg::ebaju_op_e'(wop);
                        cnt_q <= cycles_of(wop);
                        done_q <= 1'b0;
                    end
                ebaju_pkg::st_exec:
                    if (fin)
                    begin
                        state_q <= ebaju_pkg::st_idle;
                        done_q <= 1'b1;
                    end
                    else
                        cnt_q <= cnt_q - 2'h1;
                default:
                    state_q <= ebaju_pkg::st_idle;
            endcase
        end
    end

    // ------------------------------------------------------------
    // architectural registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opa_q <= ebaju_pkg::RST_WORD;
            opb_q <= ebaju_pkg::RST_WORD;
            res_q <= ebaju_pkg::RST_WORD;
            sreg_q <= ebaju_pkg::RST_SREG;
            pc_q <= ebaju_pkg::RST_PC;
        end
        else if (fin)
        begin
            res_q <= res_d;
            sreg_q <= sreg_d;
            pc_q <= pc_d;
        end
        else if (wr_idle)
        begin
            if (sel_opa)
                opa_q <= pwdata[15:0];
            if (sel_opb)
                opb_q <= pwdata[15:0];
            if (sel_sreg)
                sreg_q <= pwdata[7:0];
            if (sel_pc)
                pc_q <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // apb answer, one wait state so read data comes from a flop
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= apb_acc && !pready_q;
            pslverr_q <= apb_acc && !pready_q && !hit;
            prdata_q <= (apb_acc && !pready_q && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pc_o = pc_q;
    assign sreg_o = sreg_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire fin_is_add = fin && (op_q == ebaju_pkg::op_add_carry);
    property p_add_carry;
        fin_is_add |=> res_q[7:0] == 8'($past(opa_q[7:0]) + $past(opb_q[7:0])
            + {7'h00, $past(sreg_q[ebaju_pkg::FLG_C])});
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add with carry wrong"); // RQ1

    property p_pair_cycles;
        start && (wop == 5'h02) |=> busy [*2] ##1 (!busy && done_q);
    endproperty
    a_pair_cycles: assert property (p_pair_cycles) else $error("pair add cycles"); // RQ2

    property p_sub_borrow;
        fin && (op_q == ebaju_pkg::op_sub) |=>
            sreg_q[ebaju_pkg::FLG_C] == ($past(opa_q[7:0]) < $past(opb_q[7:0]));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong"); // RQ3

    property p_sbc_res;
        fin && (op_q == ebaju_pkg::op_difference_with_borrow) |=>
            res_q[7:0] == 8'($past(opa_q[7:0]) - $past(opb_q[7:0])
            - {7'h00, $past(sreg_q[ebaju_pkg::FLG_C])});
    endproperty
    a_sbc_res: assert property (p_sbc_res) else $error("sub with borrow wrong"); // RQ4

    property p_pair_minus;
        fin && pair_sub |=> res_q == 16'($past(opa_q) - {8'h00, $past(opb_q[7:0])});
    endproperty
    a_pair_minus: assert property (p_pair_minus) else $error("pair minus wrong"); // RQ6

    property p_logic_flags;
        fin && (op_q == ebaju_pkg::op_and) |=> !sreg_q[ebaju_pkg::FLG_V]
            && (sreg_q[ebaju_pkg::FLG_C] == $past(sreg_q[ebaju_pkg::FLG_C]))
            && (sreg_q[ebaju_pkg::FLG_H] == $past(sreg_q[ebaju_pkg::FLG_H]));
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("and flags wrong"); // RQ7

    property p_mask_low;
        fin && (op_q == ebaju_pkg::op_mask_bits_low) |=>
            res_q[7:0] == ($past(opa_q[7:0]) & ~$past(opb_q[7:0]));
    endproperty
    a_mask_low: assert property (p_mask_low) else $error("mask low wrong"); // RQ9

    property p_mul_res;
        fin && (op_q == ebaju_pkg::op_unsigned_product) |=>
            res_q == 16'($past(opa_q[7:0]) * $past(opb_q[7:0]));
    endproperty
    a_mul_res: assert property (p_mul_res) else $error("product wrong"); // RQ11

    property p_call_cycles;
        start && (wop == 5'h1b) |=> busy [*3] ##1 (!busy && (pc_q == $past(opa_q, 4)));
    endproperty
    a_call_cycles: assert property (p_call_cycles) else $error("pointer call wrong"); // RQ14

    property p_offset;
        fin && (op_q == ebaju_pkg::op_offset_branch) |=>
            pc_q == 16'($past(pc_q) + $past(opb_q) + 16'h0001);
    endproperty
    a_offset: assert property (p_offset) else $error("offset branch wrong"); // RQ15

    property p_ones;
        fin && (op_q == ebaju_pkg::op_all_ones_load) |=>
            (res_q[7:0] == 8'hff) && $stable(sreg_q);
    endproperty
    a_ones: assert property (p_ones) else $error("all ones load wrong"); // RQ16

    c_add: cover property (fin && (op_q == ebaju_pkg::op_add));
    c_frac: cover property (fin && (op_q == ebaju_pkg::op_fraction_product_signed));
    c_call: cover property (fin && (op_q == ebaju_pkg::op_pointer_subroutine_entry));
    c_err: cover property (pready_q && pslverr_q);

endmodule // ebaju_core

// file: ebaju_decoder_model.sv
// apb master standing in for the decoder and register file
// assumes one pclk domain; every change follows a rising edge
`timescale 1ns/1ps
module ebaju_decoder_model (
    // clock
    input wire logic pclk,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // answer
    input wire logic pready
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // held until pready is sampled; ok low means the wait ran out
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic ok);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && pready !== 1'b1; n++)
            @(posedge pclk);
        ok = pready === 1'b1;
        {psel, penable} <= 2'b00;
    endtask
endmodule // ebaju_decoder_model

// file: ebaju_core_tb_top.sv
// bench: fixed list of operations with random operands through apb, reads checked from a queue
// assumes ebaju_core with its one wait state apb slave
`timescale 1ns/1ps
module ebaju_core_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, ok;
    logic [7:0] paddr, sreg_o;
    logic [31:0] pwdata, prdata, seed = 32'd61;
    logic [15:0] pc_o, pc_e = 16'h0;
    logic [32:0] notes[$];
    logic [4:0] ops[$] = '{0, 1, 2, 3, 5, 7, 8, 10, 12, 14, 17, 20, 23, 26, 27, 28, 30};
    int num_errors = 0;
    int compares = 0;
    always #5 pclk = ~pclk;
    ebaju_decoder_model i_ebaju_decoder_model (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
    ebaju_core #(.ADDR_W(8)) i_ebaju_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_o(pc_o), .sreg_o(sreg_o));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // {result, flags}; untouched flags keep their preset
    function automatic logic [23:0] model(logic [4:0] op, logic [15:0] w, logic [7:0] b, f);
        logic [8:0] s;
        logic [16:0] q;
        logic [15:0] p, r;
        logic [7:0] a;
        logic c, sb, v;
        a = w[7:0];
        p = a * b;
        sb = op == 5'd3 || op == 5'd5;
        c = (op == 5'd1 || op == 5'd5) && f[0];
        s = sb ? a - b - c : a + b + c;
        q = op == 5'd2 ? w + b : w - b;
        v = op == 5'd2 ? !w[15] && q[15] : w[15] && !q[15];
        case (op)
            5'd0, 5'd1, 5'd3, 5'd5:
            begin
                r = {8'h0, s[7:0]};
                f[5:0] = {sb ? a[3:0] < 5'(b[3:0]) + c : (a[3:0] + b[3:0] + c) > 5'hf, f[4],
                    (a[7] ~^ b[7] ~^ !sb) && (s[7] != a[7]), s[7], r == 0, s[8]};
            end
            5'd2, 5'd7:
            begin
                r = q[15:0];
                f[4:0] = {q[15] ^ v, v, q[15], r == 0, q[16]};
            end
            5'd8, 5'd10, 5'd12, 5'd14:
            begin
                r = op == 5'd8 ? a & b : op == 5'd10 ? a | b : op == 5'd12 ? a ^ b : a & ~b;
                f[3:1] = {1'b0, r[7], r == 16'h0};
            end
            5'd17: r = 16'hff;
            default:
            begin
                r = op == 5'd20 ? p : {p[14:0], 1'b0};
                f[1:0] = {r == 16'h0, p[15]};
            end
        endcase
        return {r, f};
    endfunction
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_ebaju_decoder_model.xfer(w, a, d, ok);
        if (ok !== 1'b1)
        begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        notes.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic run(logic [4:0] op, logic [15:0] a, b, logic [7:0] f);
        logic [23:0] e;
        logic [15:0] ep;
        logic [7:0] ef;
        int i;
        e = model(op, a, b[7:0], f);
        ef = op >= 5'd26 ? f : e[7:0];
        ep = op == 5'd28 ? pc_e + b + 16'h1 : op == 5'd30 ? b : op >= 5'd26 ? a : pc_e;
        pc_e = ep;
        bus(1'b1, ebaju_pkg::ADDR_OPA, {16'h0, a});
        bus(1'b1, ebaju_pkg::ADDR_OPB, {16'h0, b});
        bus(1'b1, ebaju_pkg::ADDR_SREG, {24'h0, f});
        bus(1'b1, ebaju_pkg::ADDR_CTRL, {23'h0, 1'b1, 3'h0, op});
        for (i = 1; i < 9 && pc_o !== ep; i++)
        begin
            @(posedge pclk);
            #1;
        end
        // pc lands n edges after the start write; the loop counts from one
        if (op >= 5'd26)
            check(i, (op == 5'd26 || op == 5'd28) ? 3 : 4);
        rd(ebaju_pkg::ADDR_STAT, 33'h2);
        check({25'h0, sreg_o}, {25'h0, ef});
        rd(ebaju_pkg::ADDR_SREG, {25'h0, ef});
        if (op < 5'd26)
            rd(ebaju_pkg::ADDR_RES, {17'h0, e[23:8]});
        rd(ebaju_pkg::ADDR_PC, {17'h0, ep});
    endtask
    // reads are checked in order of issue
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, notes.pop_front());
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(ebaju_pkg::ADDR_PC, 33'h0);
        rd(8'h1c, {1'b1, 32'h0});
        foreach (ops[k])
            run(ops[k], 16'(rnd()), 16'(rnd()), 8'(rnd()));
        print_verdict();
    end
endmodule // ebaju_core_tb_top
